// ### rtl/ebl_bank.sv
// Purpose: One error-reporting bank: log, location, extra info, threshold.
// Assumes: Error events are one-cycle pulses synchronous to core_clk.
// Notes: Bus answers in two cycles; ce low freezes every flip-flop.
// Behaviour
// - Log bits 15:0 take the transaction error code.
// - Log bits 31:16 take the model-specific extended code.
// - Bits 56, 54:45, 42:32 take implementation-specific details.
// - Bit 43 marks an uncorrected error from consumed known-bad data.
// - Bit 44 marks a deferred error; deferred errors raise no exception.
// - A tracked deferred error is relogged uncorrected once a thread hits it in a cycle without an external error.
// - Bit 55 marks possibly corrupt thread context; meaningful when 57 clear.
// - Bit 57 marks corrupt core state and clears both global ip flags.
// - Bit 58 says the location register holds valid contents.
// - Bit 59 says extra info register zero holds valid contents.
// - Bit 60 shows mask enable; masked errors raise no exception.
// - Bit 61 marks uncorrected; else bit 44 picks deferred or corrected.
// - Bit 62 sets when logging into an already live log.
// - Deferred replaces corrected; uncorrected replaces corrected or deferred.
// - Enabled uncorrected is never replaced; enabled replaces disabled.
// - Logging writes the code and sets live bit 63.
// - Location captures the address or location given with the error.
// - Threshold counts only errors from enabled sources, one counter per bank.
// - Zero block index means no further extra info registers.
// - Nonzero index gives up to 8 extra registers at base plus index<<3; with SCALABLE set, OFS_XN_BASE reads 0.
// - Every extra register holds valid in bit 63; register zero holds the block index at 31:24.
// - Nonzero writes to the log raise a protection fault and are dropped.
// - Status is logged even for masked sources; exceptions and threshold counts need enable.
`timescale 1ns/100ps
`default_nettype none
module ebl_bank #(
  parameter int N_EXTRA = 8,
  parameter logic [7:0] BLOCK_INDEX = 8'h01,
  parameter bit SCALABLE = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire ebl_pkg::ebl_err_s err,
  input wire logic thread_hit,
  input wire logic core_corrupt_other,
  input wire ebl_pkg::ebl_req_s req,
  output logic waitrequest,
  output logic [31:0] readdata,
  output logic mce_req,
  output logic gp_fault,
  output logic restart_ip_ok,
  output logic error_ip_ok
);
  import ebl_pkg::*;

  initial begin
    if (N_EXTRA < 0 || N_EXTRA > XN_BLOCK)
      $error("N_EXTRA must be 0 to 8");
    if (N_EXTRA > 0 && BLOCK_INDEX == 8'h00)
      $error("Extra registers need a nonzero block index");
  end

  localparam int NX = (N_EXTRA > 0) ? N_EXTRA : 1;

  logic [63:0] log_r;
  logic [63:0] loc_r;
  logic [63:0] mask_r;
  logic x0_live;
  logic cnte;
  logic of_flag;
  logic [15:0] err_cnt;
  logic [62:0] xn_data [NX];
  logic ack;
  logic defer_pend;
  ebl_err_s defer_ev;

  function automatic logic [1:0] rank(input logic is_unc, input logic is_def);
    rank = is_unc ? 2'h2 : (is_def ? 2'h1 : 2'h0);
  endfunction : rank

  // Bus access: one wait cycle, then the answer
  wire active = req.read | req.write;
  assign waitrequest = active & ~ack;
  wire wr_go = req.write & ack & ce;
  wire [31:0] wd = req.writedata;
  wire wr_log_lo = wr_go && req.address == OFS_LOG_LO;
  wire wr_log_hi = wr_go && req.address == OFS_LOG_HI;
  wire log_nonzero = (wr_log_lo | wr_log_hi) && wd != 32'h0;
  wire xn_hit = req.address >= OFS_XN_LO &&
                req.address < OFS_XN_LO + 8'(8 * N_EXTRA);
  wire [2:0] xn_idx = req.address[5:3];

  // Internal event: a deferred error that has now reached a thread
  wire ext_ev = err.valid;
  wire int_ev = ~ext_ev & defer_pend & thread_hit;
  ebl_err_s ev;
  always_comb begin
    ev = err;
    if (int_ev) begin
      ev = defer_ev;
      ev.valid = 1'b1;
      ev.deferred = 1'b0;
      ev.uncorrected = 1'b1;
    end
  end

  // Software clear applied first so a same-cycle event still lands
  logic [63:0] base_log;
  always_comb begin
    base_log = log_r;
    if (wr_log_lo && !log_nonzero)
      base_log[31:0] = 32'h0;
    if (wr_log_hi && !log_nonzero)
      base_log[63:32] = 32'h0;
  end

  wire new_en = mask_r[ev.source];
  wire old_live = base_log[B_LIVE];
  wire old_en = base_log[B_EN];
  wire old_unc = base_log[B_UNCORRECTED];
  wire [1:0] new_rank = rank(ev.uncorrected, ev.deferred);
  wire [1:0] old_rank = rank(old_unc, base_log[B_DEFER]);
  wire keep_old = old_en & old_unc;
  wire do_replace = ev.valid & (~old_live | (~keep_old &
                    ((new_en & ~old_en) |
                     (new_en == old_en && new_rank > old_rank))));
  wire overflow = ev.valid & old_live;

  logic [63:0] ev_log;
  always_comb begin
    ev_log = 64'h0;
    ev_log[15:0] = ev.code;
    ev_log[31:16] = ev.ext_code;
    ev_log[56] = ev.impl[21];
    ev_log[54:45] = ev.impl[20:11];
    ev_log[42:32] = ev.impl[10:0];
    ev_log[B_POISON] = ev.poison & ev.uncorrected;
    ev_log[B_DEFER] = ev.deferred & ~ev.uncorrected;
    ev_log[B_THREAD_CORRUPT] = ev.thread_context_corrupt &
                               ~ev.core_state_corrupt;
    ev_log[B_CORE_CORRUPT] = ev.core_state_corrupt &
                             ev.uncorrected;
    ev_log[B_LOCV] = ev.loc_valid;
    ev_log[B_XV] = ev.info_valid;
    ev_log[B_EN] = new_en;
    ev_log[B_UNCORRECTED] = ev.uncorrected;
    ev_log[B_LIVE] = 1'b1;
  end

  logic [63:0] next_log;
  always_comb begin
    next_log = base_log;
    if (do_replace)
      next_log = ev_log;
    if (overflow)
      next_log[B_OVER] = 1'b1;
  end

  // Exceptions only for enabled, uncorrected errors that took the log
  wire raise_mce = do_replace & new_en & ~ev_log[B_DEFER] &
                   ev.uncorrected;
  wire cnt_hit = ev.valid & new_en & cnte;
  wire cnt_sat = err_cnt == CNT_MAX;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      log_r <= LOG_RESET;
      ack <= 1'b0;
      gp_fault <= 1'b0;
      mce_req <= 1'b0;
    end else if (ce) begin
      log_r <= next_log;
      ack <= active & ~ack;
      gp_fault <= log_nonzero;
      mce_req <= raise_mce;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loc_r <= 64'h0;
      x0_live <= 1'b0;
    end else if (ce && do_replace) begin
      if (ev.loc_valid)
        loc_r <= ev.location;
      x0_live <= ev.info_valid;
    end
  end

  // Deferred error stays tracked until a thread consumes it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      defer_pend <= 1'b0;
      defer_ev <= '0;
    end else if (ce) begin
      if (ext_ev && err.deferred && !err.uncorrected) begin
        defer_pend <= 1'b1;
        defer_ev <= err;
      end else if (int_ev) begin
        defer_pend <= 1'b0;
      end
    end
  end

  // Threshold counter saturates at the top, flagging the threshold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnte <= 1'b0;
      of_flag <= 1'b0;
      err_cnt <= CNT_RESET;
    end else if (ce) begin
      if (wr_go && req.address == OFS_X0_HI) begin
        cnte <= wd[X_CNTE - 32];
        of_flag <= wd[X_OF - 32];
        err_cnt <= wd[15:0];
      end
      if (cnt_hit && !cnt_sat) begin
        err_cnt <= err_cnt + 16'h1;
        if (err_cnt == CNT_MAX - 16'h1)
          of_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      mask_r <= MASK_RESET;
    else if (ce && wr_go && req.address == OFS_MASK_LO)
      mask_r[31:0] <= wd;
    else if (ce && wr_go && req.address == OFS_MASK_HI)
      mask_r[63:32] <= wd;
  end

  // Global restart flags: cleared by any corrupt core state, set by software
  wire core_corrupt_any = (log_r[B_LIVE] & log_r[B_CORE_CORRUPT]) |
                          core_corrupt_other;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      restart_ip_ok <= 1'b1;
      error_ip_ok <= 1'b1;
    end else if (ce) begin
      if (core_corrupt_any) begin
        restart_ip_ok <= 1'b0;
        error_ip_ok <= 1'b0;
      end else if (wr_go && req.address == OFS_GLOBAL) begin
        restart_ip_ok <= wd[0];
        error_ip_ok <= wd[1];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NX; gi++) begin : g_xn
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
          xn_data[gi] <= 63'h0;
        else if (ce && wr_go && xn_hit && xn_idx == 3'(gi)) begin
          if (req.address[2])
            xn_data[gi][62:32] <= wd[30:0];
          else
            xn_data[gi][31:0] <= wd;
        end
      end
    end
  endgenerate

  // Read side
  wire [7:0] blk = (N_EXTRA > 0) ? BLOCK_INDEX : 8'h00;
  wire [31:0] xn_addr = XN_ADDR_BASE + {21'h0, blk, 3'h0};
  wire [31:0] x0_hi = {x0_live, 1'b1, 10'h0, cnte, 2'h0, of_flag,
                       err_cnt};
  wire [31:0] x0_lo = {blk, 24'h0};
  // Compare at full width: NX can be 8, which a 3-bit cast wraps to 0
  wire [63:0] xn_sel = {1'b1,
                        xn_data[(32'(xn_idx) < 32'(NX)) ? xn_idx : 3'h0]};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (req.address)
      OFS_LOG_LO: rd_mux = log_r[31:0];
      OFS_LOG_HI: rd_mux = log_r[63:32];
      OFS_LOC_LO: rd_mux = loc_r[31:0];
      OFS_LOC_HI: rd_mux = loc_r[63:32];
      OFS_X0_LO: rd_mux = x0_lo;
      OFS_X0_HI: rd_mux = x0_hi;
      OFS_MASK_LO: rd_mux = mask_r[31:0];
      OFS_MASK_HI: rd_mux = mask_r[63:32];
      OFS_GLOBAL: rd_mux = {28'h0, SCALABLE, core_corrupt_any, error_ip_ok,
                            restart_ip_ok};
      OFS_XN_BASE: rd_mux = (blk != 8'h00 && !SCALABLE) ? xn_addr : 32'h0;
      default: begin
        if (xn_hit)
          rd_mux = req.address[2] ? xn_sel[63:32] : xn_sel[31:0];
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      readdata <= 32'h0;
    else if (ce && req.read && !ack)
      readdata <= rd_mux;
  end

  // Assertions
  a_live_on_log: assert property (@(posedge core_clk) disable iff (rst)
    ce && do_replace |=> log_r[B_LIVE] && log_r[15:0] == $past(ev.code))
    else $error("log not live after error");
  a_over_set: assert property (@(posedge core_clk) disable iff (rst)
    ce && ev.valid && base_log[B_LIVE] |=> log_r[B_OVER])
    else $error("overflow missing");
  a_uncorr_kept: assert property (@(posedge core_clk) disable iff (rst)
    ce && base_log[B_LIVE] && base_log[B_EN] && base_log[B_UNCORRECTED]
    |=> log_r[31:0] == $past(base_log[31:0]))
    else $error("enabled uncorrected log replaced");
  a_defer_no_mce: assert property (@(posedge core_clk) disable iff (rst)
    mce_req |-> !log_r[B_DEFER] && log_r[B_EN])
    else $error("exception for deferred or masked error");
  a_gp_write: assert property (@(posedge core_clk) disable iff (rst)
    ce && log_nonzero && !ev.valid |=> gp_fault && log_r == $past(log_r))
    else $error("nonzero log write not refused");
  a_ip_cleared: assert property (@(posedge core_clk) disable iff (rst)
    ce && core_corrupt_any |=> !restart_ip_ok && !error_ip_ok)
    else $error("ip flags not cleared");
  a_defer_relog: assert property (@(posedge core_clk) disable iff (rst)
    ce && int_ev && (new_en || !base_log[B_EN]) |=> log_r[B_UNCORRECTED])
    else $error("deferred error not relogged");
  a_cnt_sat: assert property (@(posedge core_clk) disable iff (rst)
    ce && cnt_hit && cnt_sat && !wr_go |=> err_cnt == CNT_MAX && of_flag)
    else $error("counter rolled over");
  a_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
    ce && active && !ack |=> !waitrequest || !active)
    else $error("bus answer late");
  a_wait_first: assert property (@(posedge core_clk) disable iff (rst)
    ce && active && !ack |-> waitrequest)
    else $error("request answered without wait");

  // Field checks on every log that lands
  a_code_ext: assert property (@(posedge core_clk) disable iff (rst)
    ce && do_replace |=> log_r[31:16] == $past(ev.ext_code))
    else $error("extended code not logged");
  a_en_mirror: assert property (@(posedge core_clk) disable iff (rst)
    ce && do_replace |=> log_r[B_EN] == $past(new_en))
    else $error("enable flag wrong");
  a_loc_flag: assert property (@(posedge core_clk) disable iff (rst)
    ce && do_replace |=> log_r[B_LOCV] == $past(ev.loc_valid))
    else $error("location flag wrong");
  a_info_flag: assert property (@(posedge core_clk) disable iff (rst)
    ce && do_replace |=> log_r[B_XV] == x0_live)
    else $error("extra info flag wrong");

  // Class flags never contradict each other in a held log
  a_class_one: assert property (@(posedge core_clk) disable iff (rst)
    log_r[B_LIVE] |-> !(log_r[B_UNCORRECTED] && log_r[B_DEFER]))
    else $error("uncorrected and deferred together");
  a_poison_unc: assert property (@(posedge core_clk) disable iff (rst)
    log_r[B_POISON] |-> log_r[B_UNCORRECTED])
    else $error("poison on a corrected error");
  a_core_unc: assert property (@(posedge core_clk) disable iff (rst)
    log_r[B_CORE_CORRUPT] |-> log_r[B_UNCORRECTED])
    else $error("core corrupt without uncorrected");
  a_thread_ctx: assert property (@(posedge core_clk) disable iff (rst)
    log_r[B_CORE_CORRUPT] |-> !log_r[B_THREAD_CORRUPT])
    else $error("thread flag beside core flag");

  // Overflow, exception, fault, counting and tracking
  a_over_sticky: assert property (@(posedge core_clk) disable iff (rst)
    ce && log_r[B_OVER] && !wr_log_hi |=> log_r[B_OVER])
    else $error("overflow lost");
  a_mce_masked: assert property (@(posedge core_clk) disable iff (rst)
    ce && !new_en |=> !mce_req)
    else $error("exception for masked error");
  a_gp_quiet: assert property (@(posedge core_clk) disable iff (rst)
    ce && !log_nonzero |=> !gp_fault)
    else $error("spurious protection fault");
  a_cnt_masked: assert property (@(posedge core_clk) disable iff (rst)
    ce && ev.valid && !new_en && !wr_go |=> $stable(err_cnt))
    else $error("masked error counted");
  a_defer_track: assert property (@(posedge core_clk) disable iff (rst)
    ce && ext_ev && err.deferred && !err.uncorrected |=> defer_pend)
    else $error("deferred error not tracked");
endmodule : ebl_bank
`default_nettype wire

// ### rtl/ebl_pkg.sv
// Purpose: Shared constants and carriers for the error bank logger.
// Assumes: 32-bit Avalon-MM register access, 64-bit registers as word pairs.
// Notes: Offsets are byte addresses; each 64-bit register is lo then hi.
package ebl_pkg;
  localparam logic [7:0] OFS_LOG_LO = 8'h00;
  localparam logic [7:0] OFS_LOG_HI = 8'h04;
  localparam logic [7:0] OFS_LOC_LO = 8'h08;
  localparam logic [7:0] OFS_LOC_HI = 8'h0C;
  localparam logic [7:0] OFS_X0_LO = 8'h10;
  localparam logic [7:0] OFS_X0_HI = 8'h14;
  localparam logic [7:0] OFS_MASK_LO = 8'h18;
  localparam logic [7:0] OFS_MASK_HI = 8'h1C;
  localparam logic [7:0] OFS_GLOBAL = 8'h20;
  localparam logic [7:0] OFS_XN_BASE = 8'h24;
  localparam logic [7:0] OFS_XN_LO = 8'h40;
  // Log bit positions
  localparam int B_POISON = 43;
  localparam int B_DEFER = 44;
  localparam int B_THREAD_CORRUPT = 55;
  localparam int B_CORE_CORRUPT = 57;
  localparam int B_LOCV = 58;
  localparam int B_XV = 59;
  localparam int B_EN = 60;
  localparam int B_UNCORRECTED = 61;
  localparam int B_OVER = 62;
  localparam int B_LIVE = 63;
  // Extra info 0 fields
  localparam int X_LIVE = 63;
  localparam int X_CTRP = 62;
  localparam int X_CNTE = 51;
  localparam int X_OF = 48;
  localparam int X_CNT_LSB = 32;
  localparam int X_BLK_LSB = 24;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [31:0] XN_ADDR_BASE = 32'hC000_0400;
  localparam int XN_BLOCK = 8;
  localparam logic [63:0] LOG_RESET = 64'h0;
  localparam logic [63:0] MASK_RESET = 64'h0;
  localparam logic [15:0] CNT_RESET = 16'h0;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
    logic [15:0] ext_code;
    logic [21:0] impl;      // bit 56, 54:45, 42:32 packed high to low
    logic poison;
    logic deferred;
    logic uncorrected;
    logic core_state_corrupt;
    logic thread_context_corrupt;
    logic loc_valid;
    logic [63:0] location;
    logic info_valid;
    logic [5:0] source;     // Index into the reporting mask
  } ebl_err_s;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ebl_req_s;
endpackage : ebl_pkg

// ### sim/tb.sv
// Purpose: Self-checking bench for one error-reporting bank.
// Assumes: Two-cycle bus answer, one-cycle event pulses, ce high except in t_freeze.
// Notes: Every bus access starts at least one edge after the previous release.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ebl_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic thread_hit = 1'b0;
  logic core_corrupt_other = 1'b0;
  logic ce = 1'b1;
  ebl_err_s err = '0;
  ebl_req_s req = '0;
  logic waitrequest, mce_req, gp_fault, restart_ip_ok, error_ip_ok;
  logic [31:0] readdata, rd;
  logic m;
  ebl_err_s a, b, c;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int gp_cnt = 0;

  ebl_bank DUT (
    .core_clk(core_clk), .rst(rst), .ce(ce), .err(err),
    .thread_hit(thread_hit), .core_corrupt_other(core_corrupt_other),
    .req(req),
    .waitrequest(waitrequest), .readdata(readdata), .mce_req(mce_req),
    .gp_fault(gp_fault), .restart_ip_ok(restart_ip_ok),
    .error_ip_ok(error_ip_ok)
  );

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (gp_fault === 1'b1) gp_cnt++;
    if (cyc == 4000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Values are sampled before the edge's own updates land
  task automatic bus(input logic [7:0] ad, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{address: ad, read: ~w, write: w, writedata: d};
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) chk(32'h0, 32'h1);
    rd = readdata;
    req <= '0;
  endtask : bus

  task automatic fire(input ebl_err_s e, output logic mce);
    @(posedge core_clk);
    err <= e;
    @(posedge core_clk);
    err <= '0;
    @(posedge core_clk);
    mce = mce_req;
  endtask : fire

  task automatic clr();
    bus(OFS_LOG_LO, 1'b1, 32'h0);
    bus(OFS_LOG_HI, 1'b1, 32'h0);
  endtask : clr

  function automatic ebl_err_s mk(input logic [15:0] cd, input logic unc,
                                  input logic df, input logic [5:0] s);
    ebl_err_s e;
    e = '0;
    e.valid = 1'b1;
    e.code = cd;
    e.ext_code = ~cd;
    e.impl = 22'h2A5A5;
    e.poison = unc;
    e.deferred = df;
    e.uncorrected = unc;
    e.thread_context_corrupt = 1'b1;
    e.loc_valid = 1'b1;
    e.location = {48'h0, cd};
    e.info_valid = 1'b1;
    e.source = s;
    return e;
  endfunction : mk

  function automatic logic [31:0] hi_of(input ebl_err_s e, input logic ov,
                                        input logic en);
    return {1'b1, ov, e.uncorrected, en, e.info_valid, e.loc_valid,
            e.core_state_corrupt, e.impl[21], e.thread_context_corrupt,
            e.impl[20:11], e.deferred, e.poison,
            e.impl[10:0]};
  endfunction : hi_of

  task automatic t_reset();
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, LOG_RESET[63:32]);
    chk({30'h0, restart_ip_ok, error_ip_ok}, 32'h3);
    bus(OFS_X0_LO, 1'b0, 32'h0);
    chk({24'h0, rd[31:24]}, 32'h1);
    bus(OFS_XN_BASE, 1'b0, 32'h0);
    chk(rd, XN_ADDR_BASE + 32'h8);
    bus(OFS_XN_LO + 8'h04, 1'b0, 32'h0);
    chk({31'h0, rd[31]}, 32'h1);
    bus(8'hF0, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset

  // Masked source still logs but must not raise an exception
  task automatic t_log();
    int g;
    a = mk(16'h1234, 1'b1, 1'b0, 6'd2);
    fire(a, m);
    chk({31'h0, m}, 32'h0);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, hi_of(a, 1'b0, 1'b0));
    bus(OFS_LOG_LO, 1'b0, 32'h0);
    chk(rd, {a.ext_code, a.code});
    bus(OFS_LOC_LO, 1'b0, 32'h0);
    chk(rd, {16'h0, a.code});
    bus(OFS_X0_HI, 1'b0, 32'h0);
    chk({31'h0, rd[31]}, 32'h1);
    g = gp_cnt;
    bus(OFS_LOG_HI, 1'b1, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(gp_cnt - g, 32'h1);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, hi_of(a, 1'b0, 1'b0));
    clr();
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask : t_log

  task automatic t_replace();
    bus(OFS_MASK_LO, 1'b1, 32'h2);
    a = mk(16'h0A0A, 1'b1, 1'b0, 6'd2);
    fire(a, m);
    b = mk(16'h0B0B, 1'b0, 1'b0, 6'd1);
    fire(b, m);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, hi_of(b, 1'b1, 1'b1));
    c = mk(16'h0C0C, 1'b1, 1'b0, 6'd1);
    fire(c, m);
    chk({31'h0, m}, 32'h1);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, hi_of(c, 1'b1, 1'b1));
    fire(mk(16'h0D0D, 1'b0, 1'b0, 6'd1), m);
    bus(OFS_LOG_LO, 1'b0, 32'h0);
    chk(rd, {c.ext_code, c.code});
    clr();
  endtask : t_replace

  task automatic t_defer();
    fire(mk(16'h1111, 1'b0, 1'b0, 6'd1), m);
    b = mk(16'h2222, 1'b0, 1'b1, 6'd1);
    fire(b, m);
    chk({31'h0, m}, 32'h0);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, hi_of(b, 1'b1, 1'b1));
    @(posedge core_clk);
    thread_hit <= 1'b1;
    @(posedge core_clk);
    thread_hit <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk({31'h0, rd[29]}, 32'h1);
    clr();
  endtask : t_defer

  task automatic t_corrupt();
    a = mk(16'h3333, 1'b1, 1'b0, 6'd1);
    a.core_state_corrupt = 1'b1;
    fire(a, m);
    repeat (2) @(posedge core_clk);
    chk({30'h0, restart_ip_ok, error_ip_ok}, 32'h0);
    clr();
    bus(OFS_GLOBAL, 1'b1, 32'h3);
    bus(OFS_GLOBAL, 1'b0, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h3);
    @(posedge core_clk);
    core_corrupt_other <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({30'h0, restart_ip_ok, error_ip_ok}, 32'h0);
    core_corrupt_other <= 1'b0;
  endtask : t_corrupt

  // Counter must ignore errors from sources masked off
  task automatic t_thresh();
    bus(OFS_X0_HI, 1'b1, 32'h0008_0000);
    fire(mk(16'h4444, 1'b0, 1'b0, 6'd1), m);
    bus(OFS_X0_HI, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h1);
    fire(mk(16'h5555, 1'b0, 1'b0, 6'd2), m);
    bus(OFS_X0_HI, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h1);
    // Top count sets the threshold flag, then the counter must not wrap
    bus(OFS_X0_HI, 1'b1, 32'h0008_FFFE);
    fire(mk(16'h6666, 1'b0, 1'b0, 6'd1), m);
    bus(OFS_X0_HI, 1'b0, 32'h0);
    chk({15'h0, rd[16:0]}, 32'h0001_FFFF);
    fire(mk(16'h7777, 1'b0, 1'b0, 6'd1), m);
    bus(OFS_X0_HI, 1'b0, 32'h0);
    chk({15'h0, rd[16:0]}, 32'h0001_FFFF);
  endtask : t_thresh

  // Low clock enable drops events and holds every flip-flop
  task automatic t_freeze();
    clr();
    @(posedge core_clk);
    ce <= 1'b0;
    fire(mk(16'h8888, 1'b1, 1'b0, 6'd1), m);
    @(posedge core_clk);
    ce <= 1'b1;
    chk({31'h0, m}, 32'h0);
    bus(OFS_LOG_HI, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask : t_freeze

  task automatic results();
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_log();
    t_replace();
    t_defer();
    t_corrupt();
    t_thresh();
    t_freeze();
    results();
  end
endmodule : tb
`default_nettype wire
